// File: su_tx_pkg.sv
package su_tx_pkg;

// ----------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------
localparam int SEQ_W = 7;
localparam int SEG_W = 3;
localparam int SEG_COUNT = 8;
localparam int LEN_W = 6;
localparam int DESC_W = 7;
localparam int DESC_REQ_POS = 6;
localparam logic [6:0] K_OUTSTANDING = 7'h07;

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
localparam logic [7:0] OFS_CTRL = 8'h00;
localparam logic [7:0] OFS_TEST_A = 8'h04;
localparam logic [7:0] OFS_TEST_B = 8'h08;
localparam logic [7:0] OFS_STAT_TWO = 8'h10;
localparam logic [7:0] OFS_STAT_FOUR = 8'h14;
localparam logic [7:0] OFS_STAT_FIVE = 8'h18;
localparam logic [7:0] OFS_STAT_SIX = 8'h1C;
localparam logic [7:0] OFS_STAT_SEVEN = 8'h20;
localparam logic [1:0] DESC_PAGE = 2'h1;
localparam int DESC_WREQ_POS = 8;

// ----------------------------------------------------------------
// Control bit positions
// ----------------------------------------------------------------
localparam int RESET_CONTROL_POSITION = 0;
localparam int MEMORY_TEST_CONTROL_POSITION = 2;
localparam int LOOPBACK_CONTROL_POSITION = 3;
localparam int CORRECTION_METHOD_POSITION = 7;
localparam int SEND_ENABLE_POSITION = 8;

// ----------------------------------------------------------------
// Values after reset and encodings
// ----------------------------------------------------------------
localparam logic [SEQ_W-1:0] SEQ_INIT = 7'h7F;
localparam logic [SEQ_W-1:0] OLDEST_INIT = 7'h00;
localparam logic [SEQ_W-1:0] SEQ_ONE = 7'h01;
localparam logic IND_INIT = 1'b1;
localparam logic [7:0] FLAG_BYTE = 8'h7E;
localparam logic [6:0] HEAD_LAST = 7'h03;
localparam logic [LEN_W-1:0] LEN_STATUS_MAX = 6'h02;
localparam logic [4:0] FW_ID_CODE = 5'h15;  // Arbitrary value

typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_SHIFT = 2'b11,
    ST_FINISH = 2'b10
} tx_state_type;

typedef enum logic [1:0] {
    UNIT_FILL = 2'h0,
    UNIT_STATUS = 2'h1,
    UNIT_NEW = 2'h2,
    UNIT_RETX = 2'h3
} unit_kind_type;

endpackage

// File: seg_desc_mem.sv
`timescale 1ns/10ps
`default_nettype none
module seg_desc_mem
    import su_tx_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic [SEG_W-1:0] wr_addr_in,
    input wire logic [DESC_W-1:0] wr_data_in,
    input wire logic clr_en_in,
    input wire logic [SEG_W-1:0] clr_addr_in,
    input wire logic [SEG_W-1:0] rd_a_addr_in,
    output logic [DESC_W-1:0] rd_a_data_out,
    input wire logic [SEG_W-1:0] rd_b_addr_in,
    output logic [DESC_W-1:0] rd_b_data_out
);

logic [DESC_W-1:0] entry_q [SEG_COUNT];
logic [DESC_W-1:0] entry_d [SEG_COUNT];

// ----------------------------------------------------------------
// Entries: host write wins over a same-cycle request clear
// ----------------------------------------------------------------
genvar i;
generate
    for (i = 0; i < SEG_COUNT; i++) begin : g_entry
        always_comb begin
            entry_d[i] = entry_q[i];
            if (clr_en_in && clr_addr_in == SEG_W'(i)) begin
                entry_d[i][DESC_REQ_POS] = 1'b0;
            end
            if (wr_en_in && wr_addr_in == SEG_W'(i)) begin
                entry_d[i] = wr_data_in;
            end
        end
        always_ff @(posedge clk_in) begin
            if (rst_in) begin
                entry_q[i] <= '0;
            end else begin
                entry_q[i] <= entry_d[i];
            end
        end
    end
endgenerate

// ----------------------------------------------------------------
// Registered read ports (read before write)
// ----------------------------------------------------------------
always_ff @(posedge clk_in) begin
    if (rst_in) begin
        rd_a_data_out <= '0;
        rd_b_data_out <= '0;
    end else begin
        rd_a_data_out <= entry_q[rd_a_addr_in];
        rd_b_data_out <= entry_q[rd_b_addr_in];
    end
end

endmodule // seg_desc_mem
`default_nettype wire

// File: signal_unit_tx_retransmit_selftest.sv
// What this block does
// - New message unit needs send enable, request, length above 2, under K outstanding.
// - Clear the segment request once a first-time message unit is fully sent.
// - Bump last-sent forward number before a first-time message unit goes out.
// - Retransmission resends units in order from the oldest unacknowledged one.
// - Negative ack with number from oldest up to below last-sent starts resending.
// - Buffer empty exactly when last-sent plus one equals oldest unacknowledged.
// - Cyclic mode resends buffered units when nothing new is ready.
// - Cyclic mode also resends when K units are outstanding.
// - Memory self-test runs while memory-test and reset control bits are both one.
// - Copy A to two even, B to two odd registers; modulo-256 sum to four statuses.
// - During self-test show the firmware code in low five status bits.
// - Loop-back routes transmit data and clock onto the receive paths.
// - Loop-back ignores external receive pins; transmit data still drives the line.
// - Loop-back carries status units as well as message units.
// - Sequence numbers are seven bits; indicator flags are one bit.
// - Unit type follows length: 0 fill-in, 1-2 status, above 2 message.
// - Length counts bytes after the length field, before the check sequence.
// - With nothing pending, send fill-in units continuously while allowed.
// - Start with sequence numbers all ones and indicators one.
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module signal_unit_tx_retransmit_selftest
    import su_tx_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    input wire logic TX_CLOCK_IN,
    input wire logic CTS_N_IN,
    input wire logic RX_DATA_IN,
    input wire logic RX_CLOCK_IN,
    input wire logic RX_BSN_VALID_IN,
    input wire logic [SEQ_W-1:0] RX_BSN_IN,
    input wire logic RX_NACK_IN,
    output logic TX_DATA_OUT,
    output logic RX_DATA_OUT,
    output logic RX_CLOCK_OUT
);

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
logic [3:0] sync1_q;
logic [3:0] sync2_q;
logic tx_clk_prev_q;
logic tx_tick;

always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
        sync1_q <= 4'h0;
        sync2_q <= 4'h0;
        tx_clk_prev_q <= 1'b0;
    end else begin
        sync1_q <= {RX_CLOCK_IN, RX_DATA_IN, CTS_N_IN, TX_CLOCK_IN};
        sync2_q <= sync1_q;
        tx_clk_prev_q <= sync2_q[0];
    end
end

// Transmit bits move on the falling edge of the line clock
assign tx_tick = tx_clk_prev_q && !sync2_q[0];

// ----------------------------------------------------------------
// Declarations shared by the groups
// ----------------------------------------------------------------
logic pend_q, pend_d, wr_q, wr_d, hready_q, hready_d;
logic [7:0] addr_q, addr_d;
logic [31:0] hrdata_q, hrdata_d;
logic rst_ctl_q, rst_ctl_d, send_q, send_d, memtest_q, memtest_d;
logic loop_q, loop_d, method_q, method_d;
logic [7:0] test_a_q, test_a_d, test_b_q, test_b_d;
logic [7:0] mt_reg_q [4];
logic [7:0] mt_reg_d [4];
logic [7:0] mt_sum_q, mt_sum_d;
logic [SEQ_W-1:0] last_q, last_d, oldest_q, oldest_d, ptr_q, ptr_d;
logic [SEQ_W-1:0] bsn_tx_q, bsn_tx_d;
logic act_q, act_d, fib_q, fib_d, bib_q, bib_d;
tx_state_type state_q, state_d;
unit_kind_type kind_q, kind_d;
logic [SEG_W-1:0] seg_q, seg_d;
logic [SEQ_W-1:0] fsn_q, fsn_d;
logic [6:0] byte_q, byte_d;
logic [2:0] bit_q, bit_d;
logic txd_q, txd_d, rxd_q, rxc_q;
logic take, mt_active, desc_wr, clr_req, clr_send;
logic new_take, retx_take;
logic [SEQ_W-1:0] retx_from;
logic [DESC_W-1:0] desc_a, desc_b;
logic [SEG_W-1:0] rd_b_addr, next_seg;
logic [SEQ_W-1:0] outstanding, rx_off, ptr_off;
logic buf_empty, retx_valid;
logic [LEN_W-1:0] unit_len;
logic [7:0] cur_byte;

assign mt_active = rst_ctl_q && memtest_q;

// ----------------------------------------------------------------
// AHB-Lite slave, one wait state on every transfer
// ----------------------------------------------------------------
assign take = HSEL_IN && HTRANS_IN[1] && hready_q;
assign desc_wr = pend_q && wr_q && addr_q[7:6] == DESC_PAGE && !addr_q[5];

always_comb begin
    pend_d = 1'b0;
    wr_d = wr_q;
    addr_d = addr_q;
    hready_d = 1'b1;
    hrdata_d = hrdata_q;
    rst_ctl_d = rst_ctl_q;
    send_d = send_q;
    memtest_d = memtest_q;
    loop_d = loop_q;
    method_d = method_q;
    test_a_d = test_a_q;
    test_b_d = test_b_q;
    if (clr_send) begin
        send_d = 1'b0;
    end
    if (take) begin
        pend_d = 1'b1;
        wr_d = HWRITE_IN;
        addr_d = HADDR_IN[7:0];
        hready_d = 1'b0;
    end
    if (pend_q && wr_q) begin
        unique case (addr_q)
            OFS_CTRL: begin
                rst_ctl_d = HWDATA_IN[RESET_CONTROL_POSITION];
                memtest_d = HWDATA_IN[MEMORY_TEST_CONTROL_POSITION];
                loop_d = HWDATA_IN[LOOPBACK_CONTROL_POSITION];
                method_d = HWDATA_IN[CORRECTION_METHOD_POSITION];
                send_d = HWDATA_IN[SEND_ENABLE_POSITION];
            end
            OFS_TEST_A: test_a_d = HWDATA_IN[7:0];
            OFS_TEST_B: test_b_d = HWDATA_IN[7:0];
            default: ;
        endcase
    end
    if (pend_q && !wr_q) begin
        hrdata_d = 32'h0000_0000;
        if (addr_q[7:6] == DESC_PAGE && !addr_q[5]) begin
            hrdata_d[LEN_W-1:0] = desc_a[LEN_W-1:0];
            hrdata_d[DESC_WREQ_POS] = desc_a[DESC_REQ_POS];
        end else begin
            unique case (addr_q)
                OFS_CTRL: begin
                    hrdata_d[RESET_CONTROL_POSITION] = rst_ctl_q;
                    hrdata_d[MEMORY_TEST_CONTROL_POSITION] = memtest_q;
                    hrdata_d[LOOPBACK_CONTROL_POSITION] = loop_q;
                    hrdata_d[CORRECTION_METHOD_POSITION] = method_q;
                    hrdata_d[SEND_ENABLE_POSITION] = send_q;
                end
                OFS_TEST_A: hrdata_d[7:0] = test_a_q;
                OFS_TEST_B: hrdata_d[7:0] = test_b_q;
                OFS_STAT_TWO: hrdata_d[7:0] = mt_active ? mt_sum_q : {1'b0, oldest_q};
                OFS_STAT_FOUR: hrdata_d[7:0] = mt_active ? {3'h0, FW_ID_CODE}
                                                         : {act_q, outstanding};
                OFS_STAT_FIVE: hrdata_d[7:0] = mt_active ? mt_sum_q : {bib_q, bsn_tx_q};
                OFS_STAT_SIX: hrdata_d[7:0] = mt_active ? mt_sum_q : {1'b0, last_q};
                OFS_STAT_SEVEN: hrdata_d[7:0] = mt_active ? mt_sum_q
                                                          : {4'h0, kind_q, state_q};
                default: ;
            endcase
        end
    end
end

always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
        pend_q <= 1'b0;
        wr_q <= 1'b0;
        addr_q <= 8'h00;
        hready_q <= 1'b1;
        hrdata_q <= 32'h0000_0000;
        rst_ctl_q <= 1'b1;
        send_q <= 1'b0;
        memtest_q <= 1'b0;
        loop_q <= 1'b0;
        method_q <= 1'b0;
        test_a_q <= 8'h00;
        test_b_q <= 8'h00;
    end else begin
        pend_q <= pend_d;
        wr_q <= wr_d;
        addr_q <= addr_d;
        hready_q <= hready_d;
        hrdata_q <= hrdata_d;
        rst_ctl_q <= rst_ctl_d;
        send_q <= send_d;
        memtest_q <= memtest_d;
        loop_q <= loop_d;
        method_q <= method_d;
        test_a_q <= test_a_d;
        test_b_q <= test_b_d;
    end
end

// ----------------------------------------------------------------
// Segment descriptors
// ----------------------------------------------------------------
seg_desc_mem u_desc (
    .clk_in(CLK_IN),
    .rst_in(RESET_IN),
    .wr_en_in(desc_wr),
    .wr_addr_in(addr_q[4:2]),
    .wr_data_in({HWDATA_IN[DESC_WREQ_POS], HWDATA_IN[LEN_W-1:0]}),
    .clr_en_in(clr_req),
    .clr_addr_in(seg_q),
    .rd_a_addr_in(HADDR_IN[4:2]),
    .rd_a_data_out(desc_a),
    .rd_b_addr_in(rd_b_addr),
    .rd_b_data_out(desc_b)
);

// ----------------------------------------------------------------
// Memory self-test
// ----------------------------------------------------------------
genvar gi;
generate
    for (gi = 0; gi < 4; gi++) begin : g_mt
        always_comb begin
            mt_reg_d[gi] = mt_reg_q[gi];
            if (mt_active) begin
                mt_reg_d[gi] = (gi % 2 == 0) ? test_a_q : test_b_q;
            end
        end
        always_ff @(posedge CLK_IN) begin
            if (RESET_IN) begin
                mt_reg_q[gi] <= 8'h00;
            end else begin
                mt_reg_q[gi] <= mt_reg_d[gi];
            end
        end
    end
endgenerate

always_comb begin
    mt_sum_d = mt_sum_q;
    if (mt_active) begin
        mt_sum_d = mt_reg_q[0] + mt_reg_q[1] + mt_reg_q[2] + mt_reg_q[3];
    end
end

always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
        mt_sum_q <= 8'h00;
    end else begin
        mt_sum_q <= mt_sum_d;
    end
end

// ----------------------------------------------------------------
// Sequence counters, all 7-bit so they wrap on their own
// ----------------------------------------------------------------
assign outstanding = last_q + SEQ_ONE - oldest_q;
assign buf_empty = (last_q + SEQ_ONE) == oldest_q;
assign rx_off = RX_BSN_IN - oldest_q;
assign ptr_off = ptr_q - oldest_q;
// A pointer overtaken by acknowledgements ends the resend run
assign retx_valid = act_q && ptr_off < outstanding;
assign next_seg = SEG_W'(last_q + SEQ_ONE);

always_comb begin
    last_d = last_q;
    oldest_d = oldest_q;
    ptr_d = ptr_q;
    act_d = act_q;
    fib_d = fib_q;
    bib_d = bib_q;
    bsn_tx_d = bsn_tx_q;
    if (new_take) begin
        last_d = last_q + SEQ_ONE;
    end
    if (retx_take) begin
        ptr_d = retx_from + SEQ_ONE;
        act_d = retx_from != last_q;
    end
    if (RX_BSN_VALID_IN && rx_off < outstanding) begin
        oldest_d = RX_BSN_IN + SEQ_ONE;
    end
    if (RX_BSN_VALID_IN && RX_NACK_IN) begin
        fib_d = !fib_q;
        if (!buf_empty && rx_off < outstanding - SEQ_ONE) begin
            ptr_d = RX_BSN_IN + SEQ_ONE;
            act_d = 1'b1;
        end
    end
    if (rst_ctl_q) begin
        last_d = SEQ_INIT;
        bsn_tx_d = SEQ_INIT;
        oldest_d = OLDEST_INIT;
        fib_d = IND_INIT;
        bib_d = IND_INIT;
        act_d = 1'b0;
    end
end

always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
        last_q <= SEQ_INIT;
        oldest_q <= OLDEST_INIT;
        ptr_q <= OLDEST_INIT;
        act_q <= 1'b0;
        fib_q <= IND_INIT;
        bib_q <= IND_INIT;
        bsn_tx_q <= SEQ_INIT;
    end else begin
        last_q <= last_d;
        oldest_q <= oldest_d;
        ptr_q <= ptr_d;
        act_q <= act_d;
        fib_q <= fib_d;
        bib_q <= bib_d;
        bsn_tx_q <= bsn_tx_d;
    end
end

// ----------------------------------------------------------------
// Transmit selection and serialiser
// ----------------------------------------------------------------
// Descriptor port follows the unit in flight, else the next new segment
assign rd_b_addr = (state_q == ST_LOAD || state_q == ST_SHIFT) ? seg_q : next_seg;
assign unit_len = (kind_q == UNIT_FILL) ? '0 : desc_b[LEN_W-1:0];

always_comb begin
    unique case (byte_q)
        7'h00: cur_byte = FLAG_BYTE;
        7'h01: cur_byte = {bib_q, bsn_tx_q};
        7'h02: cur_byte = {fib_q, fsn_q};
        7'h03: cur_byte = {2'h0, unit_len};
        default: cur_byte = {5'h00, seg_q};
    endcase
end

always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    seg_d = seg_q;
    fsn_d = fsn_q;
    byte_d = byte_q;
    bit_d = bit_q;
    txd_d = txd_q;
    new_take = 1'b0;
    retx_take = 1'b0;
    retx_from = ptr_q;
    clr_req = 1'b0;
    clr_send = 1'b0;
    unique case (state_q)
        ST_IDLE: begin
            if (tx_tick) begin
                txd_d = 1'b1;
            end
            // Nothing leaves while in reset or while the far end holds clear-to-send off
            if (!rst_ctl_q && !sync2_q[1]) begin
                state_d = ST_LOAD;
                if (retx_valid) begin
                    kind_d = UNIT_RETX;
                    retx_take = 1'b1;
                    seg_d = SEG_W'(ptr_q);
                    fsn_d = ptr_q;
                end else if (send_q && desc_b[DESC_REQ_POS] && desc_b[LEN_W-1:0] > LEN_STATUS_MAX
                             && outstanding < K_OUTSTANDING) begin
                    kind_d = UNIT_NEW;
                    new_take = 1'b1;
                    seg_d = next_seg;
                    fsn_d = last_q + SEQ_ONE;
                end else if (send_q && desc_b[DESC_REQ_POS] && desc_b[LEN_W-1:0] != '0
                             && desc_b[LEN_W-1:0] <= LEN_STATUS_MAX) begin
                    kind_d = UNIT_STATUS;
                    seg_d = next_seg;
                    fsn_d = last_q;
                end else if (method_q && !buf_empty) begin
                    // Covers nothing ready and K outstanding alike
                    kind_d = UNIT_RETX;
                    retx_take = 1'b1;
                    retx_from = oldest_q;
                    seg_d = SEG_W'(oldest_q);
                    fsn_d = oldest_q;
                end else begin
                    kind_d = UNIT_FILL;
                    fsn_d = last_q;
                end
            end
        end
        ST_LOAD: begin
            byte_d = 7'h00;
            bit_d = 3'h0;
            state_d = ST_SHIFT;
        end
        ST_SHIFT: begin
            if (tx_tick) begin
                txd_d = cur_byte[bit_q];
                bit_d = bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                    byte_d = byte_q + 7'h01;
                    if (byte_q == HEAD_LAST + 7'(unit_len)) begin
                        state_d = ST_FINISH;
                        clr_req = kind_q == UNIT_NEW || kind_q == UNIT_STATUS;
                        clr_send = kind_q == UNIT_STATUS;
                    end
                end
            end
        end
        ST_FINISH: begin
            state_d = ST_IDLE;
        end
    endcase
end

always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
        state_q <= ST_IDLE;
        kind_q <= UNIT_FILL;
        seg_q <= '0;
        fsn_q <= SEQ_INIT;
        byte_q <= 7'h00;
        bit_q <= 3'h0;
        txd_q <= 1'b1;
    end else begin
        state_q <= state_d;
        kind_q <= kind_d;
        seg_q <= seg_d;
        fsn_q <= fsn_d;
        byte_q <= byte_d;
        bit_q <= bit_d;
        txd_q <= txd_d;
    end
end

// ----------------------------------------------------------------
// Receive path and loop-back
// ----------------------------------------------------------------
always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
        rxd_q <= 1'b1;
        rxc_q <= 1'b0;
    end else begin
        rxd_q <= loop_q ? txd_q : sync2_q[2];
        rxc_q <= loop_q ? sync2_q[0] : sync2_q[3];
    end
end

assign HRDATA_OUT = hrdata_q;
assign HREADYOUT_OUT = hready_q;
assign HRESP_OUT = 1'b0;
assign TX_DATA_OUT = txd_q;
assign RX_DATA_OUT = rxd_q;
assign RX_CLOCK_OUT = rxc_q;

endmodule // signal_unit_tx_retransmit_selftest
`default_nettype wire

// File: su_tx_checker.sv
`timescale 1ns/10ps
`default_nettype none
module su_tx_checker (
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic HREADYOUT_OUT,
    input wire logic HRESP_OUT,
    input wire logic TX_CLOCK_IN,
    input wire logic TX_DATA_OUT
);
    // ----------------
    // Assertions
    // ----------------
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    logic taken;
    assign taken = HSEL_IN && HTRANS_IN[1] && HREADYOUT_OUT;
    okay_resp_a: assert property (HRESP_OUT == 1'b0) else $error("bad response");
    wait_state_a: assert property (taken |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT)
        else $error("wait state wrong");
    single_wait_a: assert property (!HREADYOUT_OUT |=> HREADYOUT_OUT)
        else $error("ready low too long");
    wait_cause_a: assert property ($fell(HREADYOUT_OUT) |-> $past(HSEL_IN && HTRANS_IN[1]))
        else $error("stall without request");
    rdata_hold_a: assert property ($changed(HRDATA_OUT) |-> $past(!HREADYOUT_OUT))
        else $error("read data moved");
    write_keeps_a: assert property (taken && HWRITE_IN |-> ##2 $stable(HRDATA_OUT))
        else $error("write moved read data");
    unmapped_zero_a: assert property (taken && !HWRITE_IN && HADDR_IN[7:0] == 8'h3C
        |-> ##2 HRDATA_OUT == 32'h0000_0000) else $error("unmapped read not zero");
    tx_on_fall_a: assert property ($changed(TX_DATA_OUT) |-> !$past(TX_CLOCK_IN, 2))
        else $error("data moved off link clock fall");
endmodule // su_tx_checker
bind signal_unit_tx_retransmit_selftest su_tx_checker i_su_tx_checker (.*);
`default_nettype wire

// File: su_link_far.sv
`timescale 1ns/10ps
`default_nettype none
module su_link_far (
    input wire logic run_in,
    output logic link_clock_out,
    output logic rx_clock_out,
    output logic rx_data_out
);
    // Receive data toggles always and receive clock while run_in, so ignoring them in loop-back is visible
    initial begin
        link_clock_out = 1'b1;
        rx_clock_out = 1'b0;
        rx_data_out = 1'b0;
        #5;
        forever begin
            #16;
            if (run_in) rx_clock_out = ~rx_clock_out;
            #16;
            if (run_in) link_clock_out = ~link_clock_out;
            rx_data_out = ~rx_data_out;
        end
    end
endmodule // su_link_far
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import su_tx_pkg::*;
;
    typedef struct {logic w; logic [7:0] a; logic [15:0] d; logic [15:0] m; int dly;} row_type;
    logic clk, rst, hsel, hwrite, run, lb_on, tx_prev, bsn_vld, nack, cts_n;
    logic [2:0] tc_hist;
    logic hready, hresp, tx_clk, rx_clk_in, rx_d_in, tx_d, rx_d, rx_clk;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [SEQ_W-1:0] bsn;
    int mismatches, cmp_count;
    row_type rows [18];
    signal_unit_tx_retransmit_selftest i_signal_unit_tx_retransmit_selftest (
        .CLK_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
        .HWRITE_IN(hwrite), .HSIZE_IN(3'b010), .HWDATA_IN(hwdata), .HRDATA_OUT(hrdata),
        .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .TX_CLOCK_IN(tx_clk), .CTS_N_IN(cts_n),
        .RX_DATA_IN(rx_d_in), .RX_CLOCK_IN(rx_clk_in), .RX_BSN_VALID_IN(bsn_vld),
        .RX_BSN_IN(bsn), .RX_NACK_IN(nack), .TX_DATA_OUT(tx_d), .RX_DATA_OUT(rx_d),
        .RX_CLOCK_OUT(rx_clk));
    su_link_far i_su_link_far (.run_in(run), .link_clock_out(tx_clk),
        .rx_clock_out(rx_clk_in), .rx_data_out(rx_d_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        ahb(1'b0, a, 32'h0000_0000, rd);
        for (int n = 0; n < 3000 && (rd & m) !== v; n++) ahb(1'b0, a, 32'h0000_0000, rd);
        chk(rd & m, v);
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Looped receive data must trail transmit data by one cycle
    always @(posedge clk) begin
        tx_prev <= tx_d;
        tc_hist <= {tc_hist[1:0], tx_clk};
        if (lb_on) chk(32'(rx_d), 32'(tx_prev));
        if (lb_on) chk(32'(rx_clk), 32'(tc_hist[2]));
    end
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
    initial begin
        {rst, hsel, hwrite, run, lb_on, bsn_vld, nack, cts_n} = 8'h81;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        htrans = 2'b00;
        bsn = 7'h00;
        mismatches = 0;
        cmp_count = 0;
        rows = '{'{0, 8'h00, 16'h0001, 16'h01FF, 0}, '{0, 8'h10, 16'h0000, 16'h007F, 0},
            '{0, 8'h1C, 16'h007F, 16'h007F, 0}, '{0, 8'h18, 16'h00FF, 16'h00FF, 0},
            '{0, 8'h3C, 16'h0000, 16'hFFFF, 0}, '{1, 8'h00, 16'h0005, 16'h0000, 0},
            '{1, 8'h04, 16'h0012, 16'h0000, 0}, '{1, 8'h08, 16'h0034, 16'h0000, 0},
            '{0, 8'h10, 16'h008C, 16'h00FF, 150}, '{0, 8'h18, 16'h008C, 16'h00FF, 0},
            '{0, 8'h1C, 16'h008C, 16'h00FF, 0}, '{0, 8'h20, 16'h008C, 16'h00FF, 0},
            '{0, 8'h14, 16'h0015, 16'h001F, 0}, '{1, 8'h00, 16'h0001, 16'h0000, 0},
            '{1, 8'h00, 16'h0005, 16'h0000, 120}, '{1, 8'h04, 16'h00A5, 16'h0000, 0},
            '{1, 8'h08, 16'h003C, 16'h0000, 0}, '{0, 8'h10, 16'h00C2, 16'h00FF, 150}};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) begin
            repeat (rows[i].dly) @(posedge clk);
            ahb(rows[i].w, rows[i].a, {16'h0000, rows[i].d}, rd);
            if (!rows[i].w) chk(rd & {16'hFFFF, rows[i].m}, {16'h0000, rows[i].d});
        end
        // Two first-time units through loop-back; seven-bit counters move
        ahb(1'b1, 8'h40, 32'h0000_0103, rd);
        ahb(1'b1, 8'h44, 32'h0000_0104, rd);
        run <= 1'b1;
        ahb(1'b1, 8'h00, 32'h0000_0108, rd);
        repeat (4) @(posedge clk);
        lb_on <= 1'b1;
        // Clear-to-send held off: nothing may leave yet
        ahb(1'b0, 8'h1C, 32'h0000_0000, rd);
        chk(rd, 32'h0000_007F);
        cts_n <= 1'b0;
        poll(8'h44, 32'h0000_0100, 32'h0000_0000);
        poll(8'h1C, 32'h0000_007F, 32'h0000_0001);
        poll(8'h14, 32'h0000_007F, 32'h0000_0002);
        // Negative ack of unit 0 acks it and resends from unit 1
        bsn_vld <= 1'b1;
        nack <= 1'b1;
        @(posedge clk);
        bsn_vld <= 1'b0;
        nack <= 1'b0;
        poll(8'h10, 32'h0000_007F, 32'h0000_0001);
        poll(8'h20, 32'h0000_000C, 32'h0000_000C);
        // Status unit in loop-back clears send; then cyclic resend of the buffer
        ahb(1'b1, 8'h48, 32'h0000_0101, rd);
        poll(8'h00, 32'h0000_0100, 32'h0000_0000);
        ahb(1'b1, 8'h00, 32'h0000_0088, rd);
        poll(8'h20, 32'h0000_000C, 32'h0000_000C);
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
